// [hw/oscc_pkg.sv]
package oscc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [13:0] OSCC_CTRL_IDX = 14'h303e;
    localparam logic [13:0] OSCC_IRQ_STATUS_IDX = 14'h3040;
    localparam logic [13:0] OSCC_IRQ_CLEAR_IDX = 14'h3041;
    localparam logic [13:0] OSCC_IRQ_ENABLE_IDX = 14'h3042;
    localparam logic [15:0] OSCC_CTRL_ADDR = {OSCC_CTRL_IDX, 2'h0};
    localparam logic [15:0] OSCC_IRQ_STATUS_ADDR = {OSCC_IRQ_STATUS_IDX, 2'h0};
    localparam logic [15:0] OSCC_IRQ_CLEAR_ADDR = {OSCC_IRQ_CLEAR_IDX, 2'h0};
    localparam logic [15:0] OSCC_IRQ_ENABLE_ADDR = {OSCC_IRQ_ENABLE_IDX, 2'h0};

    // Control register fields
    localparam int OSCC_BIT_SW_ENABLE = 7;
    localparam int OSCC_BIT_STOP_KEEPALIVE = 5;
    localparam int OSCC_BIT_OUTPUT_SOURCE = 4;
    localparam int OSCC_BIT_RANGE = 2;
    localparam int OSCC_BIT_HIGH_GAIN = 1;
    localparam int OSCC_BIT_INIT_DONE = 0;
    localparam logic [7:0] OSCC_CTRL_WMASK = 8'hb6;
    localparam logic [7:0] OSCC_CTRL_RESET = 8'h00;

    // Interrupt event bits
    localparam int OSCC_IRQ_W = 2;
    localparam int OSCC_EV_INIT_DONE = 0;
    localparam int OSCC_EV_STOPPED = 1;
    localparam logic [OSCC_IRQ_W-1:0] OSCC_IRQ_RESET = 2'h0;

    // Raw crystal cycles before the output is released
    localparam int OSCC_STARTUP_CYCLES = 4096;

    typedef enum logic [1:0] {
        OSCC_OFF,
        OSCC_STARTUP,
        OSCC_STABLE,
        OSCC_EXTCLK
    } oscc_state_e;

endpackage : oscc_pkg

// [hw/oscc_cnt_if.sv]
`timescale 1ns/10ps
`default_nettype none

// Link between the state machine and the startup counter
interface oscc_cnt_if;
    logic clear;
    logic tick;
    logic done;

    modport ctrl (output clear, output tick, input done);
    modport counter (input clear, input tick, output done);
endinterface : oscc_cnt_if

`default_nettype wire

// [hw/oscc_startup_counter.sv]
`timescale 1ns/10ps
`default_nettype none

module oscc_startup_counter #(
    parameter int CYCLES = oscc_pkg::OSCC_STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control side
    oscc_cnt_if.counter cnt
);
    import oscc_pkg::*;

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    localparam logic [W-1:0] ZERO = W'(0);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic done_reg;
    logic done_next;

    // Count ticks until done; clear restarts from zero
    always_comb
    begin
        cnt_next = cnt_reg;
        done_next = done_reg;
        if (cnt.clear)
        begin
            cnt_next = ZERO;
            done_next = 1'b0;
        end
        else if (cnt.tick && !done_reg)
        begin
            cnt_next = cnt_reg + W'(1);
            if (cnt_reg == LAST)
            begin
                done_next = 1'b1;
            end
        end
    end

    // Done flag only this counter can change
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign cnt.done = done_reg;

    AST_CNT_DONE_EXACT: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_reg) |-> ($past(cnt_reg) == LAST) && $past(cnt.tick))
        else $error("startup count done at wrong count");

    AST_CNT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        cnt.clear |=> (cnt_reg == ZERO) && !done_reg)
        else $error("counter not cleared");

endmodule : oscc_startup_counter

`default_nettype wire

// [hw/oscc_top.sv]
`timescale 1ns/10ps
`default_nettype none

module oscc_top #(
    parameter int STARTUP_CYCLES = oscc_pkg::OSCC_STARTUP_CYCLES
) (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System conditions
    input wire logic stop_mode,
    input wire logic clkgen_enable_request,
    // Clock sources
    input wire logic raw_crystal_clock,
    input wire logic clock_input_pin,
    // Clock and amplifier outputs
    output logic clock_output,
    output logic amp_enable,
    output logic high_gain_select,
    output logic range_select,
    // Interrupt
    output logic irq
);
    import oscc_pkg::*;

    oscc_cnt_if cnt_if ();

    // Control register and derived enable
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic osc_en;

    // State machine group
    oscc_state_e state_reg;
    oscc_state_e state_next;
    logic raw_q_reg;
    logic clock_output_reg;
    logic clock_output_next;
    logic amp_enable_reg;
    logic amp_enable_next;
    logic done_q_reg;

    // Interrupt group
    logic [OSCC_IRQ_W-1:0] status_reg;
    logic [OSCC_IRQ_W-1:0] status_next;
    logic [OSCC_IRQ_W-1:0] irq_en_reg;
    logic [OSCC_IRQ_W-1:0] irq_en_next;
    logic [OSCC_IRQ_W-1:0] events;
    logic irq_reg;
    logic irq_next;

    // Bus group
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic setup_phase;
    logic wr_commit;
    logic addr_hit;
    logic [7:0] ctrl_view;

    // Bus decode
    assign setup_phase = psel && !penable;
    assign wr_commit = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign addr_hit = (paddr == OSCC_CTRL_ADDR) || (paddr == OSCC_IRQ_STATUS_ADDR)
        || (paddr == OSCC_IRQ_CLEAR_ADDR) || (paddr == OSCC_IRQ_ENABLE_ADDR);

    // Read view: reserved bits zero, done flag from counter
    always_comb
    begin
        ctrl_view = ctrl_reg & OSCC_CTRL_WMASK;
        ctrl_view[OSCC_BIT_INIT_DONE] = cnt_if.done;
    end

    // Software enable path; generator request overrides Stop
    assign osc_en = clkgen_enable_request
        || (ctrl_reg[OSCC_BIT_SW_ENABLE]
        && (!stop_mode || ctrl_reg[OSCC_BIT_STOP_KEEPALIVE]));

    // Control register next value
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_commit && paddr == OSCC_CTRL_ADDR)
        begin
            // Writable bits only; done flag and reserved bits ignored
            ctrl_next = pwdata[7:0] & OSCC_CTRL_WMASK;
        end
    end

    // Control register flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= OSCC_CTRL_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Amplifier settings straight from the register; range must be set before enabling
    assign high_gain_select = ctrl_reg[OSCC_BIT_HIGH_GAIN];
    assign range_select = ctrl_reg[OSCC_BIT_RANGE];

    // Oscillator state machine and output clock
    always_comb
    begin
        state_next = state_reg;
        if (!osc_en)
        begin
            state_next = OSCC_OFF;
        end
        else if (!ctrl_reg[OSCC_BIT_OUTPUT_SOURCE])
        begin
            state_next = OSCC_EXTCLK;
        end
        else if (cnt_if.done)
        begin
            state_next = OSCC_STABLE;
        end
        else
        begin
            state_next = OSCC_STARTUP;
        end

        // Output is a sampled copy, so it lags the source by one cycle
        unique case (state_reg)
            OSCC_OFF:
            begin
                clock_output_next = 1'b0;
            end
            OSCC_STARTUP:
            begin
                clock_output_next = 1'b0;
            end
            OSCC_STABLE:
            begin
                clock_output_next = raw_crystal_clock;
            end
            OSCC_EXTCLK:
            begin
                clock_output_next = clock_input_pin;
            end
        endcase

        // Amplifier only runs while the crystal is the source
        amp_enable_next = (state_next == OSCC_STARTUP) || (state_next == OSCC_STABLE);
    end

    // Counter sees raw rising edges only while starting up
    assign cnt_if.tick = (state_reg == OSCC_STARTUP) && raw_crystal_clock && !raw_q_reg;
    assign cnt_if.clear = (state_reg == OSCC_OFF);

    // State machine flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= OSCC_OFF;
            raw_q_reg <= 1'b0;
            clock_output_reg <= 1'b0;
            amp_enable_reg <= 1'b0;
            done_q_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            raw_q_reg <= raw_crystal_clock;
            clock_output_reg <= clock_output_next;
            amp_enable_reg <= amp_enable_next;
            done_q_reg <= cnt_if.done;
        end
    end

    oscc_startup_counter #(
        .CYCLES(STARTUP_CYCLES)
    ) u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .cnt(cnt_if)
    );

    // Interrupt events: startup finished, oscillator stopped
    always_comb
    begin
        events = '0;
        events[OSCC_EV_INIT_DONE] = cnt_if.done && !done_q_reg;
        events[OSCC_EV_STOPPED] = (state_reg != OSCC_OFF) && (state_next == OSCC_OFF);
        status_next = status_reg;
        irq_en_next = irq_en_reg;
        if (wr_commit && paddr == OSCC_IRQ_CLEAR_ADDR)
        begin
            status_next = status_reg & ~pwdata[OSCC_IRQ_W-1:0];
        end
        if (wr_commit && paddr == OSCC_IRQ_ENABLE_ADDR)
        begin
            irq_en_next = pwdata[OSCC_IRQ_W-1:0];
        end
        // New event beats a clear in the same cycle
        status_next = status_next | events;
        irq_next = |(status_reg & irq_en_reg);
    end

    // Interrupt flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= OSCC_IRQ_RESET;
            irq_en_reg <= OSCC_IRQ_RESET;
            irq_reg <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            irq_en_reg <= irq_en_next;
            irq_reg <= irq_next;
        end
    end

    // APB answer: data prepared in setup, one access cycle
    always_comb
    begin
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        if (setup_phase)
        begin
            pready_next = 1'b1;
            pslverr_next = !addr_hit;
            prdata_next = 32'h0;
            if (!pwrite)
            begin
                if (paddr == OSCC_CTRL_ADDR)
                begin
                    prdata_next[7:0] = ctrl_view;
                end
                else if (paddr == OSCC_IRQ_STATUS_ADDR)
                begin
                    prdata_next[OSCC_IRQ_W-1:0] = status_reg;
                end
                else if (paddr == OSCC_IRQ_ENABLE_ADDR)
                begin
                    prdata_next[OSCC_IRQ_W-1:0] = irq_en_reg;
                end
            end
        end
    end

    // Bus flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign clock_output = clock_output_reg;
    assign amp_enable = amp_enable_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_ctrl_read;
        setup_phase && !pwrite && (paddr == OSCC_CTRL_ADDR);
    endsequence

    sequence s_ctrl_write;
        wr_commit && (paddr == OSCC_CTRL_ADDR);
    endsequence

    AST_CTRL_WRITE: assert property (
        s_ctrl_write |=> ctrl_reg == ($past(pwdata[7:0]) & OSCC_CTRL_WMASK))
        else $error("control write not stored");
    AST_RESERVED_ZERO: assert property (
        s_ctrl_read |=> !prdata_reg[6] && !prdata_reg[3] && pready_reg)
        else $error("reserved bit read nonzero");
    AST_INIT_READ: assert property (
        s_ctrl_read |=> prdata_reg[OSCC_BIT_INIT_DONE] == $past(cnt_if.done))
        else $error("done flag read wrong");
    AST_DONE_WRITE_IGNORED: assert property (
        s_ctrl_write ##0 (!cnt_if.done && !cnt_if.tick) |=> !cnt_if.done)
        else $error("software changed done flag");
    // Amplifier follows the next state, the output clock the present one
    AST_ENABLE_LOW_OFF: assert property (
        !osc_en |=> (state_reg == OSCC_OFF) && !amp_enable_reg ##1 !clock_output_reg)
        else $error("not off while disabled");
    AST_STOP_GATING: assert property (
        (clkgen_enable_request || (ctrl_reg[OSCC_BIT_SW_ENABLE] && !stop_mode)) |=> state_reg != OSCC_OFF)
        else $error("enabled but off");
    AST_STARTUP_GATED: assert property (
        (state_reg == OSCC_STARTUP) |=> !clock_output_reg)
        else $error("output leaked during startup");
    AST_STABLE_ENTRY: assert property (
        (osc_en && ctrl_reg[OSCC_BIT_OUTPUT_SOURCE] && cnt_if.done) |=> state_reg == OSCC_STABLE)
        else $error("stable state not entered");
    AST_EXT_PASS: assert property (
        (state_reg == OSCC_EXTCLK) |=> clock_output_reg == $past(clock_input_pin))
        else $error("pin clock not passed");
    AST_STABLE_PASS: assert property (
        (state_reg == OSCC_STABLE) |=> clock_output_reg == $past(raw_crystal_clock))
        else $error("crystal clock not passed");
    AST_HGO_WRITE: assert property (
        s_ctrl_write |=> high_gain_select == $past(pwdata[OSCC_BIT_HIGH_GAIN]))
        else $error("gain select not updated");
    AST_RANGE_WRITE: assert property (
        s_ctrl_write |=> range_select == $past(pwdata[OSCC_BIT_RANGE]))
        else $error("range select not updated");
    AST_OFF_CLEARS: assert property (
        (state_reg == OSCC_OFF) |=> !cnt_if.done)
        else $error("done flag survived off");
    AST_SW_ENABLE_WAKE: assert property (
        $rose(ctrl_reg[OSCC_BIT_SW_ENABLE]) && !stop_mode |=> state_reg != OSCC_OFF)
        else $error("software enable ignored");
    AST_KEEPALIVE: assert property (
        (ctrl_reg[OSCC_BIT_SW_ENABLE] && stop_mode && ctrl_reg[OSCC_BIT_STOP_KEEPALIVE]) |=> state_reg != OSCC_OFF)
        else $error("keep-alive ignored in Stop");

endmodule : oscc_top

`default_nettype wire

// [dv/oscc_partner.sv]
`timescale 1ns/10ps
`default_nettype none

// Crystal, pin clock source and clock generator request
module oscc_partner (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Controls
    input wire logic amp_enable,
    input wire logic ext_run,
    input wire logic gen_want,
    // Sources
    output logic raw_crystal_clock,
    output logic clock_input_pin,
    output logic clkgen_enable_request
);
    logic xdiv;
    logic [1:0] pdiv;

    // Crystal swings only while the amplifier runs, else rests low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xdiv <= 1'b0;
            raw_crystal_clock <= 1'b0;
        end
        else if (!amp_enable)
        begin
            xdiv <= 1'b0;
            raw_crystal_clock <= 1'b0;
        end
        else
        begin
            xdiv <= !xdiv;
            if (xdiv)
                raw_crystal_clock <= !raw_crystal_clock;
        end
    end

    // Pin clock, period six cycles, idle low when the source is off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pdiv <= 2'h0;
            clock_input_pin <= 1'b0;
        end
        else if (!ext_run)
        begin
            pdiv <= 2'h0;
            clock_input_pin <= 1'b0;
        end
        else
        begin
            pdiv <= (pdiv == 2'h2) ? 2'h0 : pdiv + 2'h1;
            if (pdiv == 2'h2)
                clock_input_pin <= !clock_input_pin;
        end
    end

    assign clkgen_enable_request = gen_want;
endmodule : oscc_partner

`default_nettype wire

// [dv/oscc_top_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module oscc_top_tb_top;
    import oscc_pkg::*;
    localparam int SUC = 8;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic stop_mode = 0;
    logic ext_run = 0;
    logic gen_want = 0;
    logic [31:0] prdata;
    logic pready, pslverr, raw, pin, req, clock_output, amp_enable, hgs, rsel, irq;
    logic [31:0] rd;
    logic er;
    logic raw_q = 0;
    logic [4:0] rows [5] = '{5'h13, 5'h09, 5'h0f, 5'h0a, 5'h00};
    int bad_count = 0;
    int compares = 0;
    int xr = 0;
    int x0;
    int n;

    oscc_top #(.STARTUP_CYCLES(SUC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .clkgen_enable_request(req), .raw_crystal_clock(raw), .clock_input_pin(pin),
        .clock_output(clock_output), .amp_enable(amp_enable), .high_gain_select(hgs), .range_select(rsel),
        .irq(irq));
    oscc_partner far_side (.pclk(pclk), .presetn(presetn), .amp_enable(amp_enable), .ext_run(ext_run),
        .gen_want(gen_want), .raw_crystal_clock(raw), .clock_input_pin(pin), .clkgen_enable_request(req));

    // 100 MHz clock
    initial
    begin
        forever #5 pclk = !pclk;
    end

    // Raw crystal rises seen while the amplifier runs
    always @(posedge pclk)
    begin
        if (amp_enable && raw && !raw_q) xr++;
        raw_q <= raw;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int w;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do
        begin
            @(posedge pclk);
            w++;
        end
        while (pready !== 1'b1 && w < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w >= 50) bad_count++;
    endtask : apb

    // Rises of the output clock over a window
    task automatic count_out(input int cycles);
        logic q;
        n = 0;
        q = clock_output;
        repeat (cycles)
        begin
            @(posedge pclk);
            if (clock_output && !q) n++;
            q = clock_output;
        end
    endtask : count_out

    task automatic close_out;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #300000;
        bad_count++;
        close_out();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OSCC_CTRL_ADDR, 0);
        chk("ctrl reset", rd, 0);
        apb(0, 16'h0000, 0);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
        apb(1, OSCC_IRQ_ENABLE_ADDR, 32'h3);
        chk("gain reset", hgs, 0);
        apb(1, OSCC_CTRL_ADDR, 32'h06);
        // Register outputs settle one edge after the commit edge
        @(posedge pclk);
        chk("range", rsel, 1);
        chk("gain", hgs, 1);
        x0 = xr;
        apb(1, OSCC_CTRL_ADDR, 32'hff);
        apb(0, OSCC_CTRL_ADDR, 0);
        chk("ctrl readback", rd, 32'hb6);
        chk("gated", clock_output, 0);
        n = 0;
        do
        begin
            apb(0, OSCC_CTRL_ADDR, 0);
            n++;
        end
        while (rd[0] !== 1'b1 && n < 200);
        chk("init done", rd, 32'hb7);
        chk("startup edges ok", (xr - x0 >= SUC) && (xr - x0 <= SUC + 2), 1);
        count_out(16);
        chk("stable rises", n, 4);
        apb(1, OSCC_CTRL_ADDR, 32'hb6);
        apb(0, OSCC_CTRL_ADDR, 0);
        chk("done kept", rd, 32'hb7);
        apb(0, OSCC_IRQ_STATUS_ADDR, 0);
        chk("status done", rd, 32'h1);
        chk("irq set", irq, 1);
        apb(1, OSCC_IRQ_CLEAR_ADDR, 32'h1);
        apb(0, OSCC_IRQ_STATUS_ADDR, 0);
        chk("status cleared", rd, 0);
        chk("irq clear", irq, 0);
        stop_mode <= 1'b1;
        count_out(16);
        chk("stop keepalive", n, 4);
        apb(1, OSCC_CTRL_ADDR, 32'h96);
        repeat (4) @(posedge pclk);
        chk("off amp", amp_enable, 0);
        count_out(16);
        chk("off static", n, 0);
        apb(0, OSCC_CTRL_ADDR, 0);
        chk("done cleared", rd, 32'h96);
        apb(0, OSCC_IRQ_STATUS_ADDR, 0);
        chk("status off", rd, 32'h2);
        chk("irq off", irq, 1);
        apb(1, OSCC_IRQ_CLEAR_ADDR, 32'h3);
        stop_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(0, OSCC_CTRL_ADDR, 0);
        chk("restart waits", rd, 32'h96);
        // Enable table: request, sw enable, keepalive, stop, expected
        foreach (rows[i])
        begin
            gen_want <= rows[i][4];
            stop_mode <= rows[i][1];
            apb(1, OSCC_CTRL_ADDR, {24'h0, rows[i][3], 1'b0, rows[i][2], 5'h16});
            repeat (4) @(posedge pclk);
            chk("enable table", amp_enable, rows[i][0]);
        end
        gen_want <= 1'b0;
        stop_mode <= 1'b0;
        ext_run <= 1'b1;
        apb(1, OSCC_CTRL_ADDR, 32'h86);
        repeat (4) @(posedge pclk);
        chk("ext amp", amp_enable, 0);
        count_out(24);
        chk("ext rises", n, 4);
        close_out();
    end
endmodule : oscc_top_tb_top

`default_nettype wire
